// ### src/wra_stack.sv
// working-register address generation and system/user stack sequencer
//
// Contract
// - 4-bit operand top bit picks slice pointer a (0) or b (1).
// - upper five bits of chosen pointer form upper address bits.
// - lower three operand bits form lower three address bits.
// - 8-bit operand with upper nibble 1100B is a working-register reference.
// - in 8-bit form, bit 3 picks pointer, bits 2..0 pick register.
// - C0H..CFH never reachable by direct register addressing.
// - call pushes program counter; return pops it back.
// - interrupt entry pushes counter and flags; interrupt return pops both.
// - stack pointer decremented before push write, incremented after pop read.
// - stack pointer always addresses the most recently pushed byte.
// - stack pointer held as high byte D8H and low byte D9H.
// - stack pointer has no reset value; software loads it first.
// - low stack pointer byte is the effective stack address.
// - low byte wrap carries or borrows into the high byte.
// - user stacks anywhere via pre-increment/pre-decrement push and post-increment/post-decrement pop.
// - slice pointers at D6H and D7H, writable by load and set-pointer.
// - after reset pointers select C0H..C7H and C8H..CFH.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps

module wra_stack
    import wra_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoder: operand resolution and set-pointer
    input wire wra_opnd_t opnd,
    output wra_waddr_t waddr,
    input wire wra_srp_t set_slice_pointers_op,
    // execution unit: stack operations
    input wire wra_stk_req_t stk_req,
    output wra_stk_rsp_t stk_rsp,
    output logic stk_busy,
    // register file access
    output wra_mem_t mem,
    input wire logic [7:0] mem_rdata
);

    // ==========================================================
    // state
    logic [7:0] rpa_q, rpa_d, rpb_q, rpb_d;
    logic [15:0] sp_q, sp_d;
    wra_seq_t st_q, st_d;
    logic [1:0] cnt_q, cnt_d;
    logic [23:0] sh_q, sh_d;
    logic usr_q, usr_d, uinc_q, uinc_d;
    logic [7:0] uptr_q, uptr_d;
    wra_mem_t mem_q, mem_d;
    wra_stk_rsp_t rsp_q, rsp_d;
    logic busy_q, busy_d;
    wra_waddr_t wa_q, wa_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic apb_take, apb_wr, idx_hit;
    logic [7:0] idx;

    // ==========================================================
    // apb slave
    always_comb begin
        idx = paddr[APB_AW-1:2];
        // hold off while the sequencer owns the stack pointer, so the two never collide
        apb_take = psel & penable & ~pready_q & (st_q == S_IDLE) & ~stk_req.valid;
        apb_wr = psel & penable & pready_q & pwrite;
        idx_hit = (idx == IDX_RPA) | (idx == IDX_RPB) | (idx == IDX_SPH) | (idx == IDX_SPL);
        pready_d = apb_take;
        pslverr_d = apb_take & ~idx_hit;
        prdata_d = '0;
        if (apb_take) begin
            case (idx)
                IDX_RPA: prdata_d = 32'(rpa_q);
                IDX_RPB: prdata_d = 32'(rpb_q);
                IDX_SPH: prdata_d = 32'(sp_q[15:8]);
                IDX_SPL: prdata_d = 32'(sp_q[7:0]);
                default: prdata_d = '0;
            endcase
        end
    end

    // ==========================================================
    // slice pointers
    always_comb begin
        rpa_d = rpa_q;
        rpb_d = rpb_q;
        if (apb_wr && idx == IDX_RPA) begin
            rpa_d = pwdata[7:0];
        end
        if (apb_wr && idx == IDX_RPB) begin
            rpb_d = pwdata[7:0];
        end
        if (set_slice_pointers_op.valid) begin
            if (set_slice_pointers_op.set_a && set_slice_pointers_op.set_b) begin
                rpa_d = set_slice_pointers_op.value;
                rpb_d = set_slice_pointers_op.value + SRP_B_STEP;
            end else if (set_slice_pointers_op.set_a) begin
                rpa_d = set_slice_pointers_op.value;
            end else if (set_slice_pointers_op.set_b) begin
                rpb_d = set_slice_pointers_op.value;
            end
        end
    end

    // ==========================================================
    // operand to register address
    always_comb begin
        logic [7:0] rp;
        logic wr_form;
        rp = opnd.value[SEL_BIT] ? rpb_q : rpa_q;
        wr_form = ~opnd.wide | (opnd.value[7:4] == WR_NIB);
        wa_d.valid = opnd.valid;
        if (wr_form) begin
            // pointer bits 2..0 are kept but never reach the address
            wa_d.addr = {rp[7:3], opnd.value[2:0]};
        end else begin
            // the 1100B nibble is always taken as working form, so C0H..CFH never go direct
            wa_d.addr = opnd.value;
        end
    end

    // ==========================================================
    // stack sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        usr_d = usr_q;
        uinc_d = uinc_q;
        uptr_d = uptr_q;
        sp_d = sp_q;
        mem_d = '0;
        rsp_d = rsp_q;
        rsp_d.done = 1'b0;
        if (apb_wr && idx == IDX_SPH) begin
            sp_d[15:8] = pwdata[7:0];
        end
        if (apb_wr && idx == IDX_SPL) begin
            sp_d[7:0] = pwdata[7:0];
        end
        case (st_q)
            S_IDLE: begin
                if (stk_req.valid) begin
                    usr_d = stk_req.op inside {STK_UPSH_INC, STK_UPSH_DEC,
                                               STK_UPOP_INC, STK_UPOP_DEC};
                    uinc_d = (stk_req.op == STK_UPSH_INC) | (stk_req.op == STK_UPOP_INC);
                    uptr_d = stk_req.user_ptr;
                    case (stk_req.op)
                        STK_PUSH, STK_UPSH_INC, STK_UPSH_DEC: begin
                            cnt_d = N_ONE;
                            sh_d = 24'(stk_req.data);
                            st_d = S_PUSH;
                        end
                        STK_CALL: begin
                            cnt_d = N_PC;
                            sh_d = 24'(stk_req.pc);
                            st_d = S_PUSH;
                        end
                        STK_INTR: begin
                            cnt_d = N_INT;
                            sh_d = {stk_req.flags, stk_req.pc};
                            st_d = S_PUSH;
                        end
                        STK_POP, STK_UPOP_INC, STK_UPOP_DEC: begin
                            cnt_d = N_ONE;
                            st_d = S_POP_RD;
                        end
                        STK_RET: begin
                            cnt_d = N_PC;
                            st_d = S_POP_RD;
                        end
                        STK_INTERRUPT_RETURN: begin
                            cnt_d = N_INT;
                            st_d = S_POP_RD;
                        end
                        default: st_d = S_IDLE;
                    endcase
                end
            end
            S_PUSH: begin
                mem_d.we = 1'b1;
                mem_d.wdata = sh_q[7:0];
                if (usr_q) begin
                    uptr_d = uinc_q ? uptr_q + 8'h01 : uptr_q - 8'h01;
                    mem_d.addr = uptr_d;
                end else begin
                    // full 16-bit step: a low-byte wrap borrows into the high byte
                    sp_d = sp_q - 16'h0001;
                    mem_d.addr = sp_d[7:0];
                end
                sh_d = sh_q >> 8;
                cnt_d = cnt_q - 2'h1;
                st_d = (cnt_q == N_ONE) ? S_DONE : S_PUSH;
            end
            S_POP_RD: begin
                mem_d.re = 1'b1;
                mem_d.addr = usr_q ? uptr_q : sp_q[7:0];
                st_d = S_POP_CAP;
            end
            S_POP_CAP: begin
                sh_d = {sh_q[15:0], mem_rdata};
                if (usr_q) begin
                    uptr_d = uinc_q ? uptr_q + 8'h01 : uptr_q - 8'h01;
                end else begin
                    sp_d = sp_q + 16'h0001;
                end
                cnt_d = cnt_q - 2'h1;
                st_d = (cnt_q == N_ONE) ? S_DONE : S_POP_RD;
            end
            S_DONE: begin
                rsp_d.done = 1'b1;
                rsp_d.pc = sh_q[15:0];
                rsp_d.flags = sh_q[23:16];
                rsp_d.data = sh_q[7:0];
                rsp_d.user_ptr = uptr_q;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
        busy_d = (st_d != S_IDLE);
    end

    // ==========================================================
    // registers
    // stack pointer has no reset: software must load it before use
    always_ff @(posedge clk_sys) begin
        sp_q <= sp_d;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rpa_q <= RPA_RST;
            rpb_q <= RPB_RST;
            st_q <= S_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            usr_q <= 1'b0;
            uinc_q <= 1'b0;
            uptr_q <= '0;
            mem_q <= '0;
            rsp_q <= '0;
            busy_q <= 1'b0;
            wa_q <= '0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            rpa_q <= rpa_d;
            rpb_q <= rpb_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            usr_q <= usr_d;
            uinc_q <= uinc_d;
            uptr_q <= uptr_d;
            mem_q <= mem_d;
            rsp_q <= rsp_d;
            busy_q <= busy_d;
            wa_q <= wa_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign waddr = wa_q;
    assign stk_rsp = rsp_q;
    assign stk_busy = busy_q;
    assign mem = mem_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence call_taken;
        st_q == S_IDLE && stk_req.valid && stk_req.op == STK_CALL;
    endsequence

    sequence interrupt_return_taken;
        st_q == S_IDLE && stk_req.valid && stk_req.op == STK_INTERRUPT_RETURN;
    endsequence

    sequence two_pushes;
        mem_q.we ##1 mem_q.we;
    endsequence

    a_short_sel_a: assert property (opnd.valid && !opnd.wide && !opnd.value[3]
        |=> wa_q.addr[7:3] == $past(rpa_q[7:3]))
        else $error("short operand did not use pointer a");

    a_short_low_bits: assert property (opnd.valid && !opnd.wide
        |=> wa_q.addr[2:0] == $past(opnd.value[2:0]))
        else $error("short operand low bits lost");

    a_wide_work_form: assert property (opnd.valid && opnd.wide
        && opnd.value[7:4] == WR_NIB
        |=> wa_q.addr == {$past(opnd.value[3]) ? $past(rpb_q[7:3]) : $past(rpa_q[7:3]),
                          $past(opnd.value[2:0])})
        else $error("wide working operand resolved wrongly");

    a_no_direct_common: assert property (opnd.valid && opnd.wide
        |=> wa_q.addr[7:4] != WR_NIB || $past(opnd.value[7:4]) == WR_NIB
            || $past(rpa_q[7:4]) == WR_NIB || $past(rpb_q[7:4]) == WR_NIB)
        else $error("direct access reached common area");

    a_push_pre_dec: assert property (st_q == S_PUSH && !usr_q
        |=> sp_q == $past(sp_q) - 16'h0001 && mem_q.we && mem_q.addr == sp_q[7:0])
        else $error("push did not pre-decrement stack pointer");

    a_pop_post_inc: assert property (st_q == S_POP_RD && !usr_q
        |=> mem_q.re && mem_q.addr == $past(sp_q[7:0]) ##0 (1'b1 ##1
            sp_q == $past(sp_q) + 16'h0001))
        else $error("pop did not read top then increment");

    a_call_pushes: assert property (call_taken |-> ##2 two_pushes ##1 rsp_q.done)
        else $error("call did not push two bytes");

    a_interrupt_return_pops: assert property (interrupt_return_taken
        |-> ##2 mem_q.re ##2 mem_q.re ##2 mem_q.re ##2 rsp_q.done)
        else $error("interrupt return did not pop three bytes");

    a_user_push_step: assert property (st_q == S_PUSH && usr_q
        |=> uptr_q == ($past(uinc_q) ? $past(uptr_q) + 8'h01 : $past(uptr_q) - 8'h01)
            && mem_q.addr == uptr_q && sp_q == $past(sp_q))
        else $error("user push stepped wrongly");

    a_apb_one_wait: assert property (psel && penable && !pready_q && st_q == S_IDLE
        && !stk_req.valid |=> pready_q ##1 !pready_q)
        else $error("apb answer timing wrong");

endmodule

// ### src/wra_pkg.sv
// constants, commands and carriers of the working-register address and stack block
package wra_pkg;

    // ==========================================================
    // register bus map (indices; byte address is four times the index)
    localparam int unsigned APB_AW = 10;
    localparam logic [7:0] IDX_RPA = 8'hD6;
    localparam logic [7:0] IDX_RPB = 8'hD7;
    localparam logic [7:0] IDX_SPH = 8'hD8;
    localparam logic [7:0] IDX_SPL = 8'hD9;

    // ==========================================================
    // reset values and addressing fields
    localparam logic [7:0] RPA_RST = 8'hC0;
    localparam logic [7:0] RPB_RST = 8'hC8;
    localparam logic [7:0] SRP_B_STEP = 8'h08;
    localparam logic [3:0] WR_NIB = 4'hC;
    localparam int unsigned SEL_BIT = 3;

    // ==========================================================
    // bytes moved per stack operation
    localparam logic [1:0] N_ONE = 2'h1;
    localparam logic [1:0] N_PC = 2'h2;
    localparam logic [1:0] N_INT = 2'h3;

    typedef enum logic [3:0] {
        STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_INTR, STK_INTERRUPT_RETURN,
        STK_UPSH_INC, STK_UPSH_DEC, STK_UPOP_INC, STK_UPOP_DEC
    } wra_stk_op_t;

    typedef enum logic [2:0] {S_IDLE, S_PUSH, S_POP_RD, S_POP_CAP, S_DONE} wra_seq_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic wide;
        logic [7:0] value;
    } wra_opnd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } wra_waddr_t;

    typedef struct packed {
        logic valid;
        logic set_a;
        logic set_b;
        logic [7:0] value;
    } wra_srp_t;

    typedef struct packed {
        logic valid;
        wra_stk_op_t op;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] data;
        logic [7:0] user_ptr;
    } wra_stk_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] data;
        logic [7:0] user_ptr;
    } wra_stk_rsp_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wra_mem_t;

endpackage

// ### tb/wra_rf_model.sv
// register file model on the far side of the stack sequencer
`timescale 1ns/1ps

module wra_rf_model
    import wra_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register file port
    input wire wra_mem_t mem,
    output logic [7:0] mem_rdata
);
    logic [7:0] rf [256];
    logic tog = 1'b0;

    // ==========================================================
    // storage
    always @(posedge clk_sys) begin
        tog <= ~tog;
        if (mem.we === 1'b1) begin
            rf[mem.addr] <= mem.wdata;
        end
    end

    // outside a read strobe the data toggles, so a stale byte is never trusted
    assign mem_rdata = (mem.re === 1'b1) ? rf[mem.addr] : {8{tog}};
endmodule

// ### tb/working_reg_addr_and_stack_tb.sv
// self-checking bench for working-register addressing and stack sequencing
`timescale 1ns/1ps

module working_reg_addr_and_stack_tb
    import wra_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wra_opnd_t opnd = '0;
    wra_waddr_t waddr;
    wra_srp_t set_slice_pointers_op = '0;
    wra_stk_req_t stk_req = '0;
    wra_stk_rsp_t stk_rsp;
    logic stk_busy;
    wra_mem_t mem;
    logic [7:0] mem_rdata;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] sp;
    logic [7:0] up, rpa, rpb;
    logic [7:0] rfm [256];
    logic [7:0] qa[$];
    logic [7:0] qs[$];

    always #12.5 clk_sys = ~clk_sys;

    wra_stack dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .opnd(opnd), .waddr(waddr), .set_slice_pointers_op(set_slice_pointers_op), .stk_req(stk_req),
        .stk_rsp(stk_rsp), .stk_busy(stk_busy), .mem(mem), .mem_rdata(mem_rdata));

    wra_rf_model rf (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));

    // ==========================================================
    // monitors and closing
    always @(posedge clk_sys) begin
        if (mem.we === 1'b1 || mem.re === 1'b1) begin
            qs.push_back(mem.addr);
        end
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task summarize;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // ==========================================================
    // bus and port drivers
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
             input logic [31:0] erd, input logic eerr);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(32'(pready), 32'h1);
        if (!wr) chk(prdata, erd);
        chk(32'(pslverr), 32'(eerr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task opchk(input logic w, input logic [7:0] v);
        logic [7:0] rp, e;
        rp = v[SEL_BIT] ? rpb : rpa;
        e = (!w || v[7:4] == WR_NIB) ? {rp[7:3], v[2:0]} : v;
        @(posedge clk_sys);
        opnd <= {1'b1, w, v};
        @(posedge clk_sys);
        opnd.valid <= 1'b0;
        @(posedge clk_sys);
        chk(32'(waddr), {23'h0, 1'b1, e});
    endtask

    task setp(input logic a, input logic b, input logic [7:0] v);
        @(posedge clk_sys);
        set_slice_pointers_op <= {1'b1, a, b, v};
        @(posedge clk_sys);
        set_slice_pointers_op.valid <= 1'b0;
        if (a) rpa = v;
        if (b) rpb = a ? v + SRP_B_STEP : v;
    endtask

    function void mpush(input logic [7:0] v);
        sp = sp - 16'h0001;
        rfm[sp[7:0]] = v;
        qa.push_back(sp[7:0]);
    endfunction

    function logic [7:0] mpop();
        mpop = rfm[sp[7:0]];
        qa.push_back(sp[7:0]);
        sp = sp + 16'h0001;
    endfunction

    task spchk;
        apb(1'b0, IDX_SPH, 8'h00, 32'(sp[15:8]), 1'b0);
        apb(1'b0, IDX_SPL, 8'h00, 32'(sp[7:0]), 1'b0);
    endtask

    task sop(input wra_stk_op_t op, input logic [15:0] pc, input logic [7:0] fl,
             input logic [7:0] d);
        wra_stk_rsp_t r;
        logic [15:0] epc;
        logic [7:0] efl, ed;
        int n, elat;
        qa.delete();
        qs.delete();
        @(posedge clk_sys);
        stk_req <= {1'b1, op, pc, fl, d, up};
        @(posedge clk_sys);
        stk_req.valid <= 1'b0;
        case (op)
            STK_PUSH: mpush(d);
            STK_POP: ed = mpop();
            STK_CALL: begin
                mpush(pc[7:0]);
                mpush(pc[15:8]);
            end
            STK_RET: begin
                epc[15:8] = mpop();
                epc[7:0] = mpop();
            end
            STK_INTR: begin
                mpush(pc[7:0]);
                mpush(pc[15:8]);
                mpush(fl);
            end
            STK_INTERRUPT_RETURN: begin
                efl = mpop();
                epc[15:8] = mpop();
                epc[7:0] = mpop();
            end
            STK_UPSH_INC: begin
                up = up + 8'h01;
                rfm[up] = d;
                qa.push_back(up);
            end
            STK_UPSH_DEC: begin
                up = up - 8'h01;
                rfm[up] = d;
                qa.push_back(up);
            end
            STK_UPOP_INC: begin
                ed = rfm[up];
                qa.push_back(up);
                up = up + 8'h01;
            end
            default: begin
                ed = rfm[up];
                qa.push_back(up);
                up = up - 8'h01;
            end
        endcase
        // one cycle per byte pushed, two per byte popped, plus start and finish
        elat = qa.size() + 2;
        if (op inside {STK_POP, STK_RET, STK_INTERRUPT_RETURN, STK_UPOP_INC, STK_UPOP_DEC}) begin
            elat = elat + qa.size();
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n == 1) chk(32'(stk_busy), 32'h1);
        end while (stk_rsp.done !== 1'b1 && n < 30);
        r = stk_rsp;
        chk(32'(stk_busy), 32'h0);
        chk(32'(n), 32'(elat));
        #1;
        chk(32'(qs.size()), 32'(qa.size()));
        foreach (qa[i]) chk(32'(qs[i]), 32'(qa[i]));
        if (op inside {STK_RET, STK_INTERRUPT_RETURN}) chk(32'(r.pc), 32'(epc));
        if (op == STK_INTERRUPT_RETURN) chk(32'(r.flags), 32'(efl));
        if (op inside {STK_POP, STK_UPOP_INC, STK_UPOP_DEC}) chk(32'(r.data), 32'(ed));
        if (op >= STK_UPSH_INC) chk(32'(r.user_ptr), 32'(up));
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hbd47c562));
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rpa = RPA_RST;
        rpb = RPB_RST;
        apb(1'b0, IDX_RPA, 8'h00, 32'(RPA_RST), 1'b0);
        apb(1'b0, IDX_RPB, 8'h00, 32'(RPB_RST), 1'b0);
        apb(1'b0, 8'h00, 8'h00, 32'h0, 1'b1);
        apb(1'b1, 8'h3F, 8'h55, 32'h0, 1'b1);
        for (int i = 0; i < 16; i++) begin
            opchk(1'b0, 8'(i));
            opchk(1'b1, 8'hC0 + 8'(i));
        end
        for (int i = 0; i < 12; i++) begin
            setp(i % 3 != 1, i % 3 != 0, 8'($urandom));
            apb(1'b0, IDX_RPA, 8'h00, 32'(rpa), 1'b0);
            apb(1'b0, IDX_RPB, 8'h00, 32'(rpb), 1'b0);
            repeat (4) opchk(1'($urandom), 8'($urandom));
        end
        rpa = 8'h70;
        apb(1'b1, IDX_RPA, rpa, 32'h0, 1'b0);
        opchk(1'b0, 8'h06);
        opchk(1'b1, 8'hC3);
        // low byte starts at 01 so the second push borrows into the high byte
        sp = {8'($urandom), 8'h01};
        apb(1'b1, IDX_SPH, sp[15:8], 32'h0, 1'b0);
        apb(1'b1, IDX_SPL, sp[7:0], 32'h0, 1'b0);
        sop(STK_PUSH, 16'h0000, 8'h00, 8'($urandom));
        sop(STK_PUSH, 16'h0000, 8'h00, 8'($urandom));
        spchk();
        sop(STK_POP, 16'h0000, 8'h00, 8'h00);
        sop(STK_POP, 16'h0000, 8'h00, 8'h00);
        spchk();
        sp[7:0] = 8'hFF;
        apb(1'b1, IDX_SPL, sp[7:0], 32'h0, 1'b0);
        sop(STK_CALL, 16'($urandom), 8'h00, 8'h00);
        sop(STK_INTR, 16'($urandom), 8'($urandom), 8'h00);
        sop(STK_INTERRUPT_RETURN, 16'h0000, 8'h00, 8'h00);
        sop(STK_RET, 16'h0000, 8'h00, 8'h00);
        spchk();
        up = 8'($urandom);
        sop(STK_UPSH_INC, 16'h0000, 8'h00, 8'($urandom));
        sop(STK_UPOP_DEC, 16'h0000, 8'h00, 8'h00);
        sop(STK_UPSH_DEC, 16'h0000, 8'h00, 8'($urandom));
        sop(STK_UPOP_INC, 16'h0000, 8'h00, 8'h00);
        spchk();
        summarize();
    end
endmodule
